// ===== design/bgw_pkg.sv
package bgw_pkg;

  // channel geometry: acyclic bytes first, cyclic bytes last
  localparam int CHAN_BYTES = 12;
  localparam int ACY_BYTES  = 8;
  localparam int CYC_FIRST  = 8;
  localparam int CNT_W      = 20;

  // register port offsets (channel bytes sit at 0x00..0x0b)
  localparam logic [4:0] OFS_REQ   = 5'h00;
  localparam logic [4:0] OFS_CHEND = 5'h0c;
  localparam logic [4:0] OFS_ADDR  = 5'h10;
  localparam logic [4:0] OFS_INFO  = 5'h11;

  // cyclic byte positions inside the channel
  localparam int CYC_CMD  = 8;
  localparam int CYC_SETH = 9;
  localparam int CYC_SETL = 10;
  localparam int CYC_FLG  = 8;
  localparam int CYC_CURH = 9;
  localparam int CYC_CURL = 10;
  localparam int CYC_RSV  = 11;

  // bit positions in the command and flag bytes
  localparam int CMD_ON   = 0;
  localparam int CMD_OFF  = 1;
  localparam int FLG_ON   = 0;
  localparam int FLG_RDY  = 1;
  localparam int FLG_FLT  = 2;
  localparam int FLG_WRN  = 3;
  localparam int FLG_PERR = 4;

  // acyclic message layout
  localparam int MSG_CODE = 0;
  localparam int MSG_STAT = 1;
  localparam int MSG_HI   = 2;
  localparam int MSG_LO   = 3;
  localparam logic [7:0] STAT_OK  = 8'h00;
  localparam logic [7:0] STAT_REJ = 8'h01;

  // acyclic request codes
  typedef enum logic [7:0] {
    REQ_FAULT_CAUSE = 8'h01,
    REQ_POSITION    = 8'h02,
    REQ_PHASE_CUR   = 8'h03,
    REQ_SET_DLY_SC  = 8'h10,
    REQ_SET_INST_SC = 8'h11,
    REQ_SET_IMBAL   = 8'h12,
    REQ_SET_UNDERV  = 8'h13,
    REQ_SET_OVERV   = 8'h14,
    REQ_SET_LSHED   = 8'h15
  } bgw_req_t;

  // parameter targets presented to the breaker
  typedef enum logic [2:0] {
    PAR_DLY_SC  = 3'h0,
    PAR_INST_SC = 3'h1,
    PAR_IMBAL   = 3'h2,
    PAR_UNDERV  = 3'h3,
    PAR_OVERV   = 3'h4,
    PAR_LSHED   = 3'h5
  } bgw_par_t;

  // current zero-forcing threshold for the basic module
  localparam logic [6:0] ZERO_PCT = 7'h12;
  localparam logic [6:0] FULL_PCT = 7'h64;

  // station address selectors
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] DIGIT_TEN = 4'ha;

  // cyclic refresh period
  localparam int CLK_NS        = 50;
  localparam int CYC_PERIOD_NS = 1000000;
  localparam int CYC_CLKS      = CYC_PERIOD_NS / CLK_NS;

  // synchronised breaker and panel inputs
  typedef struct packed {
    logic        on_state;
    logic        ready;
    logic        grp_fault;
    logic        grp_warn;
    logic        grp_perr;
    logic        metering;
    logic [1:0]  cause;
    logic [1:0]  position;
    logic [15:0] cur;
    logic [15:0] rated;
    logic [3:0]  tens;
    logic [3:0]  units;
  } bgw_pins_t;

endpackage

// ===== design/bgw_gateway.sv
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module bgw_gateway #(
  parameter int CYC_CLKS = bgw_pkg::CYC_CLKS
) (
  input  wire logic        i_mclk,        // 20 MHz clock
  input  wire logic        i_rst,         // synchronous reset, active high
  input  wire logic [4:0]  i_addr,        // register address
  input  wire logic [7:0]  i_wdata,       // write data
  input  wire logic        i_wr,          // write strobe
  input  wire logic        i_rd,          // read strobe
  output logic      [7:0]  o_rdata,       // read data, cycle after i_rd
  input  wire logic        i_brk_on,      // breaker is closed
  input  wire logic        i_brk_ready,   // ready to close
  input  wire logic        i_grp_fault,   // group fault
  input  wire logic        i_grp_warn,    // group warning
  input  wire logic        i_grp_perr,    // group processor error
  input  wire logic        i_metering,    // metering module fitted
  input  wire logic [1:0]  i_trip_cause,  // 0 earth,1 delayed,2 instant,3 other
  input  wire logic [1:0]  i_position,    // draw-out position state
  input  wire logic [15:0] i_phase_cur,   // measured phase current
  input  wire logic [15:0] i_rated_cur,   // rated breaker current
  input  wire logic [3:0]  i_addr_tens,   // tens selector
  input  wire logic [3:0]  i_addr_units,  // units selector
  output logic      [15:0] o_brk_setting, // overload setting current
  output logic             o_brk_on_cmd,  // remote switch-on
  output logic             o_brk_off_cmd, // remote switch-off
  output logic             o_brk_stb,     // cyclic refresh pulse
  output logic      [2:0]  o_par_sel,     // parameter target
  output logic      [15:0] o_par_val,     // parameter value
  output logic             o_par_stb,     // parameter write pulse
  output logic      [6:0]  o_station      // bus station address
);

  typedef struct packed {
    bgw_pkg::bgw_pins_t                       sy1;
    bgw_pkg::bgw_pins_t                       sy2;
    logic [bgw_pkg::CHAN_BYTES-1:0][7:0]      img_out;
    logic [bgw_pkg::CHAN_BYTES-1:0][7:0]      img_in;
    logic [bgw_pkg::CNT_W-1:0]                tick_cnt;
    logic                                     tick;
    logic [7:0]                               rdata;
    logic [15:0]                              brk_setting;
    logic                                     brk_on;
    logic                                     brk_off;
    logic                                     brk_stb;
    logic [2:0]                               par_sel;
    logic [15:0]                              par_val;
    logic                                     par_stb;
    logic [6:0]                               station;
  } bgw_state_t;

  localparam logic [bgw_pkg::CNT_W-1:0] TICK_LAST = bgw_pkg::CNT_W'(CYC_CLKS - 1);

  bgw_state_t         s;
  bgw_state_t         next_s;
  bgw_pkg::bgw_pins_t pins;

  // reported current: basic module forces small readings to zero
  function automatic logic [15:0] cur_report(input logic [15:0] cur,
                                             input logic [15:0] rated,
                                             input logic        meter);
    logic [22:0] lhs;
    logic [22:0] rhs;
    lhs = 23'(cur) * 23'(bgw_pkg::FULL_PCT);
    rhs = 23'(rated) * 23'(bgw_pkg::ZERO_PCT);
    if (meter) begin
      cur_report = cur;
    end else if (lhs < rhs) begin
      cur_report = 16'h0000;
    end else begin
      cur_report = cur;
    end
  endfunction

  // raw pins gathered for the synchroniser
  always_comb begin
    pins.on_state  = i_brk_on;
    pins.ready     = i_brk_ready;
    pins.grp_fault = i_grp_fault;
    pins.grp_warn  = i_grp_warn;
    pins.grp_perr  = i_grp_perr;
    pins.metering  = i_metering;
    pins.cause     = i_trip_cause;
    pins.position  = i_position;
    pins.cur       = i_phase_cur;
    pins.rated     = i_rated_cur;
    pins.tens      = i_addr_tens;
    pins.units     = i_addr_units;
  end

  // next-state logic for the whole gateway
  always_comb begin
    logic [3:0]  tens;
    logic [3:0]  units;
    logic [15:0] rep;
    logic [15:0] val;
    logic [7:0]  code;
    tens  = 4'h0;
    units = 4'h0;
    rep   = 16'h0000;
    val   = 16'h0000;
    code  = 8'h00;
    next_s         = s;
    next_s.sy1     = pins;
    next_s.sy2     = s.sy1;
    next_s.tick    = 1'b0;
    next_s.brk_stb = 1'b0;
    next_s.par_stb = 1'b0;
    next_s.rdata   = 8'h00;

    // refresh divider, no master request involved
    if (s.tick_cnt >= TICK_LAST) begin
      next_s.tick_cnt = '0;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 1'b1;
    end

    // cyclic exchange in both directions on each tick
    if (s.tick) begin
      rep = cur_report(s.sy2.cur, s.sy2.rated, s.sy2.metering);
      next_s.img_in[bgw_pkg::CYC_FLG] = {3'h0, s.sy2.grp_perr, s.sy2.grp_warn,
                                         s.sy2.grp_fault, s.sy2.ready,
                                         s.sy2.on_state};
      next_s.img_in[bgw_pkg::CYC_CURH] = rep[15:8];
      next_s.img_in[bgw_pkg::CYC_CURL] = rep[7:0];
      next_s.img_in[bgw_pkg::CYC_RSV]  = 8'h00;
      next_s.brk_setting = {s.img_out[bgw_pkg::CYC_SETH],
                            s.img_out[bgw_pkg::CYC_SETL]};
      next_s.brk_on  = s.img_out[bgw_pkg::CYC_CMD][bgw_pkg::CMD_ON];
      next_s.brk_off = s.img_out[bgw_pkg::CYC_CMD][bgw_pkg::CMD_OFF];
      next_s.brk_stb = 1'b1;
    end

    // station address from two decimal selectors, digits above nine clamp
    tens  = (s.sy2.tens > bgw_pkg::DIGIT_MAX) ? bgw_pkg::DIGIT_MAX : s.sy2.tens;
    units = (s.sy2.units > bgw_pkg::DIGIT_MAX) ? bgw_pkg::DIGIT_MAX : s.sy2.units;
    next_s.station = 7'(tens) * 7'(bgw_pkg::DIGIT_TEN) + 7'(units);
    // the link side has no rate field: it locks to the master's rate

    // master writes land in the output image of the channel
    if (i_wr && (i_addr < bgw_pkg::OFS_CHEND)) begin
      next_s.img_out[i_addr[3:0]] = i_wdata;
    end

    // a write to the first byte is the only thing that starts a message
    if (i_wr && (i_addr == bgw_pkg::OFS_REQ)) begin
      code = i_wdata;
      val  = {s.img_out[bgw_pkg::MSG_HI], s.img_out[bgw_pkg::MSG_LO]};
      for (int b = 0; b < bgw_pkg::ACY_BYTES; b++) begin
        next_s.img_in[b] = 8'h00;
      end
      next_s.img_in[bgw_pkg::MSG_CODE] = code;
      next_s.img_in[bgw_pkg::MSG_STAT] = bgw_pkg::STAT_OK;
      case (code)
        bgw_pkg::REQ_FAULT_CAUSE: begin
          if (s.sy2.grp_fault) begin
            next_s.img_in[bgw_pkg::MSG_LO] = {6'h00, s.sy2.cause};
          end else begin
            next_s.img_in[bgw_pkg::MSG_STAT] = bgw_pkg::STAT_REJ;
          end
        end
        bgw_pkg::REQ_POSITION: begin
          next_s.img_in[bgw_pkg::MSG_LO] = {6'h00, s.sy2.position};
        end
        bgw_pkg::REQ_PHASE_CUR: begin
          rep = cur_report(s.sy2.cur, s.sy2.rated, s.sy2.metering);
          next_s.img_in[bgw_pkg::MSG_HI] = rep[15:8];
          next_s.img_in[bgw_pkg::MSG_LO] = rep[7:0];
        end
        bgw_pkg::REQ_SET_DLY_SC, bgw_pkg::REQ_SET_INST_SC,
        bgw_pkg::REQ_SET_IMBAL: begin
          next_s.par_sel = 3'(code - bgw_pkg::REQ_SET_DLY_SC);
          next_s.par_val = val;
          next_s.par_stb = 1'b1;
        end
        bgw_pkg::REQ_SET_UNDERV, bgw_pkg::REQ_SET_OVERV,
        bgw_pkg::REQ_SET_LSHED: begin
          if (s.sy2.metering) begin
            next_s.par_sel = 3'(code - bgw_pkg::REQ_SET_DLY_SC);
            next_s.par_val = val;
            next_s.par_stb = 1'b1;
          end else begin
            next_s.img_in[bgw_pkg::MSG_STAT] = bgw_pkg::STAT_REJ;
          end
        end
        default: begin
          next_s.img_in[bgw_pkg::MSG_STAT] = bgw_pkg::STAT_REJ;
        end
      endcase
    end

    // read port: channel input image, address and fitted module
    if (i_rd) begin
      if (i_addr < bgw_pkg::OFS_CHEND) begin
        next_s.rdata = s.img_in[i_addr[3:0]];
      end else if (i_addr == bgw_pkg::OFS_ADDR) begin
        next_s.rdata = {1'b0, s.station};
      end else if (i_addr == bgw_pkg::OFS_INFO) begin
        next_s.rdata = {7'h00, s.sy2.metering};
      end else begin
        next_s.rdata = 8'h00;
      end
    end
  end

  // single state register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign o_rdata       = s.rdata;
  assign o_brk_setting = s.brk_setting;
  assign o_brk_on_cmd  = s.brk_on;
  assign o_brk_off_cmd = s.brk_off;
  assign o_brk_stb     = s.brk_stb;
  assign o_par_sel     = s.par_sel;
  assign o_par_val     = s.par_val;
  assign o_par_stb     = s.par_stb;
  assign o_station     = s.station;

  // checks on the gateway's own behaviour
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence req_write_s;
    i_wr && (i_addr == bgw_pkg::OFS_REQ);
  endsequence

  sequence no_req_s;
    !(i_wr && (i_addr == bgw_pkg::OFS_REQ));
  endsequence

  par_on_request_a: assert property (o_par_stb |-> $past(i_wr) && ($past(i_addr) == bgw_pkg::OFS_REQ)) else $error("parameter pulse without request");

  resp_hold_a: assert property (no_req_s |=> $stable(s.img_in[bgw_pkg::ACY_BYTES-1:0])) else $error("acyclic response changed without request");

  status_copy_a: assert property (s.tick |=> s.img_in[bgw_pkg::CYC_FLG][4:0] == {$past(s.sy2.grp_perr), $past(s.sy2.grp_warn), $past(s.sy2.grp_fault), $past(s.sy2.ready), $past(s.sy2.on_state)}) else $error("status byte not refreshed");

  setting_fwd_a: assert property (s.tick |=> o_brk_stb && (o_brk_setting == $past({s.img_out[bgw_pkg::CYC_SETH], s.img_out[bgw_pkg::CYC_SETL]}))) else $error("setting current not forwarded");

  zero_force_a: assert property (s.tick && !s.sy2.metering && (s.sy2.cur == 16'h0000 || 23'(s.sy2.cur) * 23'(bgw_pkg::FULL_PCT) < 23'(s.sy2.rated) * 23'(bgw_pkg::ZERO_PCT)) |=> {s.img_in[bgw_pkg::CYC_CURH], s.img_in[bgw_pkg::CYC_CURL]} == 16'h0000) else $error("small current not zeroed");

  meter_pass_a: assert property (s.tick && s.sy2.metering |=> {s.img_in[bgw_pkg::CYC_CURH], s.img_in[bgw_pkg::CYC_CURL]} == $past(s.sy2.cur)) else $error("metered current altered");

  cause_reply_a: assert property (req_write_s ##0 (i_wdata == bgw_pkg::REQ_FAULT_CAUSE) ##0 s.sy2.grp_fault |=> s.img_in[bgw_pkg::MSG_LO] == {6'h00, $past(s.sy2.cause)}) else $error("fault cause not reported");

  meter_only_a: assert property (o_par_stb && (o_par_sel >= bgw_pkg::PAR_UNDERV) |-> $past(s.sy2.metering)) else $error("metering setting accepted without module");

  addr_range_a: assert property (##1 o_station <= 7'h63) else $error("station address out of range");

  tick_gap_a: assert property (o_brk_stb |=> !o_brk_stb [*8]) else $error("refresh pulses too close");

endmodule

`default_nettype wire

// ===== sim/bgw_breaker_model.sv
`timescale 1ns/1ns
`default_nettype none

// behavioural breaker and release: follows cyclic commands, logs parameter writes
module bgw_breaker_model (
  input  wire logic        i_mclk,    // gateway clock
  input  wire logic [15:0] i_setting, // overload setting current
  input  wire logic        i_on_cmd,  // remote switch-on
  input  wire logic        i_off_cmd, // remote switch-off
  input  wire logic        i_stb,     // cyclic refresh pulse
  input  wire logic [2:0]  i_par_sel, // parameter target
  input  wire logic [15:0] i_par_val, // parameter value
  input  wire logic        i_par_stb, // parameter write pulse
  output logic             o_on,      // breaker closed
  output logic             o_ready,   // ready to close
  output logic             o_fault,   // group fault
  output logic             o_warn,    // group warning
  output logic             o_perr,    // group processor error
  output logic             o_meter,   // metering module fitted
  output logic [1:0]       o_cause,   // trip cause code
  output logic [1:0]       o_pos,     // draw-out position
  output logic [15:0]      o_cur,     // measured phase current
  output logic [15:0]      o_rated    // rated current
);
  bgw_pkg::bgw_pins_t knob = '0;  // scenario settings, set by the bench
  logic               closed = 1'b0;
  logic [15:0]        setting = 16'h0000;
  int                 par_cnt = 0;
  logic [2:0]         last_sel = 3'h0;
  logic [15:0]        last_val = 16'h0000;

  // cyclic commands act only on a refresh pulse, parameters on their own pulse
  always @(posedge i_mclk) begin
    if (i_stb === 1'b1) begin
      setting <= i_setting;
      if (i_on_cmd === 1'b1) closed <= 1'b1;
      else if (i_off_cmd === 1'b1) closed <= 1'b0;
    end
    if (i_par_stb === 1'b1) begin
      par_cnt  <= par_cnt + 1;
      last_sel <= i_par_sel;
      last_val <= i_par_val;
    end
  end

  // breaker status levels; a faulted or closed breaker is not ready
  assign o_on    = closed;
  assign o_ready = !closed && !knob.grp_fault;
  assign o_fault = knob.grp_fault;
  assign o_warn  = knob.grp_warn;
  assign o_perr  = knob.grp_perr;
  assign o_meter = knob.metering;
  assign o_cause = knob.cause;
  assign o_pos   = knob.position;
  assign o_cur   = knob.cur;
  assign o_rated = knob.rated;
endmodule

`default_nettype wire

// ===== sim/test_breaker_fieldbus_data_gateway.sv
`timescale 1ns/1ns
`default_nettype none

module test_breaker_fieldbus_data_gateway;
  localparam int CYC = 16; // shortened refresh period
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [4:0]  i_addr = 5'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic [3:0]  tens = 4'h4;
  logic [3:0]  units = 4'h2;
  wire  [7:0]  rdata;
  wire  [15:0] setting, par_val, cur, rated;
  wire  [2:0]  par_sel;
  wire  [6:0]  station;
  wire  [1:0]  cause, pos;
  wire         on_cmd, off_cmd, brk_stb, par_stb, on, rdy, flt, wrn, perr, met;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;

  bgw_gateway #(.CYC_CLKS(CYC)) bgw_gateway_i (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_brk_on(on), .i_brk_ready(rdy), .i_grp_fault(flt), .i_grp_warn(wrn),
    .i_grp_perr(perr), .i_metering(met), .i_trip_cause(cause), .i_position(pos),
    .i_phase_cur(cur), .i_rated_cur(rated), .i_addr_tens(tens), .i_addr_units(units),
    .o_brk_setting(setting), .o_brk_on_cmd(on_cmd), .o_brk_off_cmd(off_cmd),
    .o_brk_stb(brk_stb), .o_par_sel(par_sel), .o_par_val(par_val), .o_par_stb(par_stb),
    .o_station(station));

  bgw_breaker_model bgw_breaker_model_i (.i_mclk(i_mclk), .i_setting(setting),
    .i_on_cmd(on_cmd), .i_off_cmd(off_cmd), .i_stb(brk_stb), .i_par_sel(par_sel),
    .i_par_val(par_val), .i_par_stb(par_stb), .o_on(on), .o_ready(rdy), .o_fault(flt),
    .o_warn(wrn), .o_perr(perr), .o_meter(met), .o_cause(cause), .o_pos(pos),
    .o_cur(cur), .o_rated(rated));

  // clock and cycle ceiling
  initial begin
    forever #25 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register port: one-cycle strobes, read data in the following cycle
  task wr(input int a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= 5'(a);
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task rd_chk(input int a, input logic [7:0] e);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= 5'(a);
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // waits for the next refresh pulse, n returns the cycles spent after the first one
  task tick;
    n = 0;
    @(posedge i_mclk);
    #1;
    while (brk_stb !== 1'b1 && n < 2 * CYC) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk(brk_stb, 16'h1);
  endtask

  task knobs(input logic f, p, m, input logic [1:0] c, input logic [15:0] cu, ra);
    @(posedge i_mclk);
    bgw_breaker_model_i.knob <= {2'b00, f, 1'b0, p, m, c, c, cu, ra, 8'h00};
    repeat (6) @(posedge i_mclk);
  endtask

  // value bytes first, then the code; the response must fill bytes zero to seven
  task acy(input logic [7:0] code, lo, st, input logic [15:0] d, input logic dc);
    wr(bgw_pkg::MSG_HI, 8'h5a);
    wr(bgw_pkg::MSG_LO, lo);
    wr(bgw_pkg::OFS_REQ, code);
    rd_chk(bgw_pkg::MSG_CODE, code);
    rd_chk(bgw_pkg::MSG_STAT, st);
    if (dc) begin
      rd_chk(bgw_pkg::MSG_HI, d[15:8]);
      rd_chk(bgw_pkg::MSG_LO, d[7:0]);
    end
    for (int b = 4; b < bgw_pkg::ACY_BYTES; b++) rd_chk(b, 8'h00);
  endtask

  task t_station;
    repeat (6) @(posedge i_mclk);
    rd_chk(bgw_pkg::OFS_ADDR, 8'd42);
    tens  <= 4'hc;
    units <= 4'hf;
    repeat (6) @(posedge i_mclk);
    rd_chk(bgw_pkg::OFS_ADDR, 8'd99);
    rd_chk(5'h1f, 8'h00);
    $display("test station done");
  endtask

  task t_cyc_out;
    knobs(1'b1, 1'b1, 1'b1, 2'h0, 16'h1234, 16'h1000);
    tick();
    tick();
    chk(16'(n), 16'(CYC - 1));
    rd_chk(bgw_pkg::CYC_FLG, 8'(1 << bgw_pkg::FLG_FLT | 1 << bgw_pkg::FLG_PERR));
    rd_chk(bgw_pkg::CYC_CURH, 8'h12);
    rd_chk(bgw_pkg::CYC_CURL, 8'h34);
    rd_chk(bgw_pkg::CYC_RSV, 8'h00);
    $display("test cyclic out done");
  endtask

  task t_cyc_in;
    int c0;
    c0 = bgw_breaker_model_i.par_cnt;
    wr(bgw_pkg::CYC_CMD, 8'(1 << bgw_pkg::CMD_ON));
    wr(bgw_pkg::CYC_SETH, 8'hab);
    wr(bgw_pkg::CYC_SETL, 8'hcd);
    tick();
    tick();
    chk(setting, 16'habcd);
    chk(bgw_breaker_model_i.closed, 16'h1);
    tick();
    rd_chk(bgw_pkg::CYC_FLG, 8'(1 | 1 << bgw_pkg::FLG_FLT | 1 << bgw_pkg::FLG_PERR));
    wr(bgw_pkg::CYC_CMD, 8'(1 << bgw_pkg::CMD_OFF));
    tick();
    tick();
    chk(bgw_breaker_model_i.closed, 16'h0);
    chk(16'(bgw_breaker_model_i.par_cnt - c0), 16'h0);
    $display("test cyclic in done");
  endtask

  task t_acy_par;
    int c0;
    logic ok;
    for (int m = 0; m < 2; m++) begin
      knobs(1'b0, 1'b0, m[0], 2'h0, 16'h0000, 16'h0064);
      rd_chk(bgw_pkg::OFS_INFO, 8'(m));
      for (int c = 0; c < 7; c++) begin
        c0 = bgw_breaker_model_i.par_cnt;
        ok = (c < 3) || (m == 1 && c < 6);
        acy(8'h10 + 8'(c), 8'(c), ok ? bgw_pkg::STAT_OK : bgw_pkg::STAT_REJ, 16'h0, 1'b0);
        chk(16'(bgw_breaker_model_i.par_cnt - c0), 16'(ok));
        if (ok) chk(bgw_breaker_model_i.last_val, {8'h5a, 8'(c)});
        if (ok) chk(bgw_breaker_model_i.last_sel, 16'(c));
      end
    end
    $display("test acyclic settings done");
  endtask

  task t_fault;
    for (int c = 0; c < 4; c++) begin
      knobs(1'b1, 1'b0, 1'b0, 2'(c), 16'h0000, 16'h0064);
      acy(bgw_pkg::REQ_FAULT_CAUSE, 8'h00, bgw_pkg::STAT_OK, 16'(c), 1'b1);
      acy(bgw_pkg::REQ_POSITION, 8'h00, bgw_pkg::STAT_OK, 16'(c), 1'b1);
    end
    knobs(1'b0, 1'b0, 1'b0, 2'h1, 16'h0000, 16'h0064);
    acy(bgw_pkg::REQ_FAULT_CAUSE, 8'h00, bgw_pkg::STAT_REJ, 16'h0, 1'b0);
    $display("test fault cause done");
  endtask

  task t_cur;
    logic [15:0] cu;
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      cu = i[0] ? 16'd18 : 16'd17;
      e  = (i < 2 && cu * 100 < 100 * 18) ? 16'h0000 : cu;
      knobs(1'b0, 1'b0, i[1], 2'h0, cu, 16'd100);
      acy(bgw_pkg::REQ_PHASE_CUR, 8'h00, bgw_pkg::STAT_OK, e, 1'b1);
      tick();
      tick();
      rd_chk(bgw_pkg::CYC_CURH, e[15:8]);
      rd_chk(bgw_pkg::CYC_CURL, e[7:0]);
    end
    $display("test current done");
  endtask

  // last response must survive value-byte writes and refreshes
  task t_hold;
    wr(bgw_pkg::MSG_HI, 8'hff);
    wr(bgw_pkg::MSG_LO, 8'hee);
    tick();
    rd_chk(bgw_pkg::MSG_CODE, bgw_pkg::REQ_PHASE_CUR);
    rd_chk(bgw_pkg::MSG_HI, 8'h00);
    rd_chk(bgw_pkg::MSG_LO, 8'd18);
    $display("test response hold done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge i_mclk);
    #1 chk({brk_stb, par_stb, on_cmd, off_cmd, 5'h00, station}, 16'h0000);
    @(posedge i_mclk);
    i_rst <= 1'b0;
    t_station();
    t_cyc_out();
    t_cyc_in();
    t_acy_par();
    t_fault();
    t_cur();
    t_hold();
    print_verdict();
  end
endmodule

`default_nettype wire
